// >>> rcf_map.svh
// clock, channel count, field widths, throttle channel and timing figures of the receiver control block
`ifndef RCF_MAP_SVH
`define RCF_MAP_SVH

`define RCF_CLK_MHZ 10
`define RCF_CH_COUNT 6
`define RCF_VAL_W 10
`define RCF_ID_W 32
`define RCF_THR_CH 0
`define RCF_HOLD_W 8

`define RCF_FRAME_US 22000
`define RCF_MIN_PW_US 1000
`define RCF_STEP_NS 1000
`define RCF_CLK_NS 100

`define RCF_LOSS_US 44000
`define RCF_RESTORE_US 4000
`define RCF_CONNECT_FRAMES 16
`define RCF_SETTLE_CYC 4

`define RCF_FAST_HALF_MS 100
`define RCF_SLOW_HALF_MS 500
`define RCF_HOLD_PAUSE_MS 1000

`endif

// >>> rcf_pkg.sv
// types and shared arithmetic of the receiver control block
`include "rcf_map.svh"
package rcf_pkg;
  typedef enum logic [2:0] {
    RCF_ST_SETTLE,
    RCF_ST_BIND,
    RCF_ST_WAIT,
    RCF_ST_CONN,
    RCF_ST_HOLD
  } rcf_state_e;

  typedef enum logic [2:0] {
    RCF_LED_OFF,
    RCF_LED_SOLID,
    RCF_LED_FAST,
    RCF_LED_SLOW,
    RCF_LED_COUNT
  } rcf_led_mode_e;

  typedef logic [`RCF_VAL_W-1:0] rcf_val_t;
  typedef logic [`RCF_ID_W-1:0] rcf_id_t;

  // pulse width in clock cycles for a channel value
  function automatic logic [31:0] rcf_pulse_cycles(input rcf_val_t v);
    rcf_pulse_cycles = 32'(`RCF_MIN_PW_US * `RCF_CLK_MHZ)
                     + 32'(v) * 32'(`RCF_STEP_NS / `RCF_CLK_NS);
  endfunction

  function automatic logic [31:0] rcf_ms_cycles(input int ms);
    rcf_ms_cycles = 32'(ms * 1000 * `RCF_CLK_MHZ);
  endfunction
endpackage

// >>> rcf_if.sv
// carriers between the control core, the servo pulse generator and the led driver
`include "rcf_map.svh"
interface rcf_servo_if;
  rcf_pkg::rcf_val_t value [`RCF_CH_COUNT];
  logic [`RCF_CH_COUNT-1:0] enable;
  logic [`RCF_CH_COUNT-1:0] pulse;
  modport ctl (output value, output enable, input pulse);
  modport gen (input value, input enable, output pulse);
endinterface

interface rcf_led_if;
  rcf_pkg::rcf_led_mode_e mode;
  logic [`RCF_HOLD_W-1:0] count;
  logic led;
  modport ctl (output mode, output count, input led);
  modport drv (input mode, input count, output led);
endinterface

// >>> rcf_servo_gen.sv
// servo pulse generator: one shared frame counter, one pulse per enabled channel
`include "rcf_map.svh"
module rcf_servo_gen #(
  parameter int unsigned FRAME_CYC = `RCF_FRAME_US * `RCF_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic srst,
  rcf_servo_if.gen sv
);
  logic [31:0] frame_cnt;

  always_ff @(posedge clk_sys) begin
    if (srst || frame_cnt == 32'(FRAME_CYC - 1)) begin
      frame_cnt <= 32'h0;
    end else begin
      frame_cnt <= frame_cnt + 32'h1;
    end
  end

  // disabled channel stays low for the whole frame: no pulse at all
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `RCF_CH_COUNT; i++) begin
      if (srst) begin
        sv.pulse[i] <= 1'b0;
      end else begin
        sv.pulse[i] <= sv.enable[i] && (frame_cnt < rcf_pkg::rcf_pulse_cycles(sv.value[i]));
      end
    end
  end
endmodule // rcf_servo_gen

// >>> rcf_led_drv.sv
// status led pattern driver: solid, fast blink, slow blink and count-then-pause
`include "rcf_map.svh"
module rcf_led_drv #(
  parameter int unsigned FAST_HALF_CYC = `RCF_FAST_HALF_MS * 1000 * `RCF_CLK_MHZ,
  parameter int unsigned SLOW_HALF_CYC = `RCF_SLOW_HALF_MS * 1000 * `RCF_CLK_MHZ,
  parameter int unsigned PAUSE_CYC = `RCF_HOLD_PAUSE_MS * 1000 * `RCF_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic srst,
  rcf_led_if.drv ld
);
  logic [31:0] tmr;
  logic [31:0] next_limit;
  logic [`RCF_HOLD_W:0] step;
  logic in_pause;
  logic phase;
  rcf_pkg::rcf_led_mode_e mode_q;

  always_comb begin
    next_limit = 32'(FAST_HALF_CYC - 1);
    if (ld.mode == rcf_pkg::RCF_LED_SLOW) begin
      next_limit = 32'(SLOW_HALF_CYC - 1);
    end else if (ld.mode == rcf_pkg::RCF_LED_COUNT && in_pause) begin
      next_limit = 32'(PAUSE_CYC - 1);
    end
  end

  // restart the pattern on a mode change only; a new count while already in count mode keeps the running pattern
  always_ff @(posedge clk_sys) begin
    if (srst || ld.mode != mode_q) begin
      tmr <= 32'h0;
      step <= '0;
      in_pause <= 1'b0;
      phase <= 1'b1;
    end else if (tmr >= next_limit) begin
      tmr <= 32'h0;
      if (ld.mode != rcf_pkg::RCF_LED_COUNT) begin
        phase <= ~phase;
      end else if (in_pause) begin
        in_pause <= 1'b0;
        step <= '0;
        phase <= 1'b1;
      end else if (step == {ld.count, 1'b0} - 1'b1) begin
        in_pause <= 1'b1;
        phase <= 1'b0;
      end else begin
        step <= step + 1'b1;
        phase <= ~phase;
      end
    end else begin
      tmr <= tmr + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_q <= rcf_pkg::RCF_LED_OFF;
      ld.led <= 1'b0;
    end else begin
      mode_q <= ld.mode;
      case (ld.mode)
        rcf_pkg::RCF_LED_SOLID: ld.led <= 1'b1;
        rcf_pkg::RCF_LED_FAST, rcf_pkg::RCF_LED_SLOW: ld.led <= phase;
        rcf_pkg::RCF_LED_COUNT: ld.led <= phase && !in_pause;
        default: ld.led <= 1'b0;
      endcase
    end
  end
endmodule // rcf_led_drv

// >>> rcf_receiver.sv
// receiver control core: bind, connection state, failsafe outputs and status led
`include "rcf_map.svh"
module rcf_receiver #(
  parameter int unsigned FRAME_CYC = `RCF_FRAME_US * `RCF_CLK_MHZ,
  parameter int unsigned LOSS_CYC = `RCF_LOSS_US * `RCF_CLK_MHZ,
  parameter int unsigned CONNECT_FRAMES = `RCF_CONNECT_FRAMES,
  parameter int unsigned FAST_HALF_CYC = `RCF_FAST_HALF_MS * 1000 * `RCF_CLK_MHZ,
  parameter int unsigned SLOW_HALF_CYC = `RCF_SLOW_HALF_MS * 1000 * `RCF_CLK_MHZ,
  parameter int unsigned PAUSE_CYC = `RCF_HOLD_PAUSE_MS * 1000 * `RCF_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic power_and_pair_port,
  input wire logic brownout_pin,
  input wire logic link_valid,
  input wire logic link_bind,
  input wire logic [`RCF_ID_W-1:0] link_id,
  input wire logic [`RCF_CH_COUNT*`RCF_VAL_W-1:0] link_values,
  input wire logic nv_valid,
  input wire logic [`RCF_ID_W-1:0] nv_id,
  input wire logic [`RCF_VAL_W-1:0] nv_failsafe,
  output logic nv_write,
  output logic [`RCF_ID_W-1:0] nv_id_out,
  output logic [`RCF_VAL_W-1:0] nv_failsafe_out,
  output logic [`RCF_CH_COUNT-1:0] servo_out,
  output logic throttle_channel_port,
  output logic status_led,
  output logic connected,
  output logic failsafe,
  output logic bind_mode,
  output logic [`RCF_HOLD_W-1:0] hold_count
);

  rcf_pkg::rcf_state_e state;
  logic [2:0] pair_sync;
  logic [2:0] brown_sync;
  logic pair_level;
  logic brown_level;
  logic [3:0] settle_cnt;
  logic [31:0] loss_cnt;
  logic [7:0] good_run;
  logic [`RCF_ID_W-1:0] paired_id;
  logic paired;
  rcf_pkg::rcf_val_t fs_value;
  rcf_pkg::rcf_val_t ch_value [`RCF_CH_COUNT];
  logic brownout_seen;
  logic good_frame;
  logic bind_frame;
  logic take_frame;
  logic link_timeout;
  logic [`RCF_CH_COUNT-1:0] next_enable;

  rcf_servo_if sv ();
  rcf_led_if ld ();

  // pins pass three flops; a level counts once the last two agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pair_sync <= 3'h0;
      pair_level <= 1'b0;
    end else begin
      pair_sync <= {pair_sync[1:0], power_and_pair_port};
      if (pair_sync[2] == pair_sync[1]) begin
        pair_level <= pair_sync[2];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      brown_sync <= 3'h0;
      brown_level <= 1'b0;
    end else begin
      brown_sync <= {brown_sync[1:0], brownout_pin};
      if (brown_sync[2] == brown_sync[1]) begin
        brown_level <= brown_sync[2];
      end
    end
  end

  // the learned code is only compared once pairing exists
  assign good_frame = link_valid && !link_bind && paired && (link_id == paired_id);
  assign bind_frame = link_valid && link_bind;
  // a bind in bind mode is accepted too, else a long bind wait would time out at once
  assign take_frame = good_frame || (state == rcf_pkg::RCF_ST_BIND && bind_frame);
  assign link_timeout = (loss_cnt >= 32'(LOSS_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      settle_cnt <= 4'h0;
    end else if (state == rcf_pkg::RCF_ST_SETTLE) begin
      settle_cnt <= settle_cnt + 4'h1;
    end
  end

  // cycles since the last accepted frame
  always_ff @(posedge clk_sys) begin
    if (srst || take_frame) begin
      loss_cnt <= 32'h0;
    end else if (!link_timeout) begin
      loss_cnt <= loss_cnt + 32'h1;
    end
  end

  // first connection needs a run of clean frames; a gap restarts the run
  always_ff @(posedge clk_sys) begin
    if (srst || state != rcf_pkg::RCF_ST_WAIT) begin
      good_run <= 8'h0;
    end else if (good_frame) begin
      // a frame after a gap starts a fresh run rather than being lost
      if (link_timeout) begin
        good_run <= 8'h1;
      end else if (good_run != 8'hff) begin
        good_run <= good_run + 8'h1;
      end
    end else if (link_timeout) begin
      good_run <= 8'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= rcf_pkg::RCF_ST_SETTLE;
    end else begin
      case (state)
        rcf_pkg::RCF_ST_SETTLE: begin
          // jumper is a strap: sampled once the synchroniser has settled
          if (settle_cnt == 4'(`RCF_SETTLE_CYC)) begin
            if (pair_level || !nv_valid) begin
              state <= rcf_pkg::RCF_ST_BIND;
            end else begin
              state <= rcf_pkg::RCF_ST_WAIT;
            end
          end
        end
        rcf_pkg::RCF_ST_BIND: begin
          if (bind_frame) begin
            state <= rcf_pkg::RCF_ST_CONN;
          end
        end
        rcf_pkg::RCF_ST_WAIT: begin
          if (good_frame && good_run >= 8'(CONNECT_FRAMES - 1)) begin
            state <= rcf_pkg::RCF_ST_CONN;
          end
        end
        rcf_pkg::RCF_ST_CONN: begin
          if (link_timeout) begin
            state <= rcf_pkg::RCF_ST_HOLD;
          end
        end
        rcf_pkg::RCF_ST_HOLD: begin
          // one good frame is enough once locked in
          if (good_frame) begin
            state <= rcf_pkg::RCF_ST_CONN;
          end
        end
        default: state <= rcf_pkg::RCF_ST_SETTLE;
      endcase
    end
  end

  // pairing: code and throttle failsafe come from the bind frame
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      paired <= 1'b0;
      paired_id <= '0;
    end else if (state == rcf_pkg::RCF_ST_SETTLE) begin
      paired <= nv_valid;
      paired_id <= nv_id;
    end else if (state == rcf_pkg::RCF_ST_BIND && bind_frame) begin
      paired <= 1'b1;
      paired_id <= link_id;
    end
  end

  // reloaded from the store each power-up, replaced only by a new bind
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fs_value <= '0;
    end else if (state == rcf_pkg::RCF_ST_SETTLE) begin
      fs_value <= nv_failsafe;
    end else if (state == rcf_pkg::RCF_ST_BIND && bind_frame) begin
      fs_value <= link_values[`RCF_THR_CH*`RCF_VAL_W +: `RCF_VAL_W];
    end
  end

  // one-cycle strobe to the external store when a bind completes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nv_write <= 1'b0;
    end else begin
      nv_write <= (state == rcf_pkg::RCF_ST_BIND) && bind_frame;
    end
  end

  assign nv_id_out = paired_id;
  assign nv_failsafe_out = fs_value;

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `RCF_CH_COUNT; i++) begin
      if (srst) begin
        ch_value[i] <= '0;
      end else if (take_frame) begin
        ch_value[i] <= link_values[i*`RCF_VAL_W +: `RCF_VAL_W];
      end
    end
  end

  // hold count lives only in volatile flops: power-up reset clears it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hold_count <= '0;
    end else if (state == rcf_pkg::RCF_ST_CONN && link_timeout && hold_count != '1) begin
      hold_count <= hold_count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      brownout_seen <= 1'b0;
    end else if (brown_level) begin
      brownout_seen <= 1'b1;
    end
  end

  always_comb begin
    next_enable = '0;
    case (state)
      rcf_pkg::RCF_ST_CONN: next_enable = '1;
      // only throttle pulses in failsafe, the rest go quiet
      rcf_pkg::RCF_ST_HOLD: next_enable[`RCF_THR_CH] = 1'b1;
      default: next_enable = '0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < `RCF_CH_COUNT; i++) begin
      sv.value[i] = ch_value[i];
    end
    if (state == rcf_pkg::RCF_ST_HOLD) begin
      sv.value[`RCF_THR_CH] = fs_value;
    end
    sv.enable = next_enable;
  end

  rcf_servo_gen #(
    .FRAME_CYC(FRAME_CYC)
  ) rcf_servo_gen_inst (
    .clk_sys(clk_sys),
    .srst(srst),
    .sv(sv)
  );

  // bind blink wins, then brownout, then hold count, then the connected light
  always_comb begin
    ld.count = hold_count;
    if (state == rcf_pkg::RCF_ST_BIND) begin
      ld.mode = rcf_pkg::RCF_LED_FAST;
    end else if (brownout_seen) begin
      ld.mode = rcf_pkg::RCF_LED_SLOW;
    end else if (hold_count != '0) begin
      ld.mode = rcf_pkg::RCF_LED_COUNT;
    end else if (state == rcf_pkg::RCF_ST_CONN) begin
      ld.mode = rcf_pkg::RCF_LED_SOLID;
    end else begin
      ld.mode = rcf_pkg::RCF_LED_OFF;
    end
  end

  rcf_led_drv #(
    .FAST_HALF_CYC(FAST_HALF_CYC),
    .SLOW_HALF_CYC(SLOW_HALF_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) rcf_led_drv_inst (
    .clk_sys(clk_sys),
    .srst(srst),
    .ld(ld)
  );

  assign servo_out = sv.pulse;
  assign throttle_channel_port = sv.pulse[`RCF_THR_CH];
  assign status_led = ld.led;
  assign connected = (state == rcf_pkg::RCF_ST_CONN);
  assign failsafe = (state == rcf_pkg::RCF_ST_HOLD);
  assign bind_mode = (state == rcf_pkg::RCF_ST_BIND);
endmodule // rcf_receiver

// >>> rcf_servo_model.sv
// partner model: servo and speed controller inputs timing each channel pulse
`include "rcf_map.svh"
module rcf_servo_model (
  input wire logic clk_sys,
  input wire logic [`RCF_CH_COUNT-1:0] servo_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a speed controller arms on its first pulse, so pulses[0] doubles as arm count
  int run [6];
  int width [6];
  int pulses [6];
  always @(posedge clk_sys) begin
    for (int i = 0; i < 6; i++) begin
      if (servo_in[i]) begin
        run[i] <= run[i] + 1;
      end else if (run[i] > 0) begin
        width[i] <= run[i];
        pulses[i] <= pulses[i] + 1;
        run[i] <= 0;
      end
    end
  end
endmodule // rcf_servo_model

// >>> rcf_receiver_assertions.sv
// port assertions for the receiver control core, bound into its top module
`include "rcf_map.svh"
module rcf_receiver_assertions #(
  parameter int unsigned LOSS_CYC = 1000,
  parameter int unsigned FAST_HALF_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic link_valid,
  input wire logic link_bind,
  input wire logic [`RCF_CH_COUNT*`RCF_VAL_W-1:0] link_values,
  input wire logic nv_write,
  input wire logic [`RCF_VAL_W-1:0] nv_failsafe_out,
  input wire logic [`RCF_CH_COUNT-1:0] servo_out,
  input wire logic status_led,
  input wire logic connected,
  input wire logic failsafe,
  input wire logic bind_mode,
  input wire logic [`RCF_HOLD_W-1:0] hold_count
);
  localparam int BLINK_WIN = FAST_HALF_CYC + 2;
  // foreign frames also clear it, so it never overstates the silence
  int unsigned quiet_cnt;
  always_ff @(posedge clk_sys) begin
    if (srst || link_valid) begin
      quiet_cnt <= 0;
    end else if (quiet_cnt <= LOSS_CYC) begin
      quiet_cnt <= quiet_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  property p_bind_blink;
    $rose(bind_mode) |-> ##[1:BLINK_WIN] status_led ##[1:BLINK_WIN] !status_led;
  endproperty
  a_bind_blink: assert property (p_bind_blink) else $error("bind led idle");
  property p_bind_conn;
    link_valid && link_bind && bind_mode |=> connected && !bind_mode && nv_write;
  endproperty
  a_bind_conn: assert property (p_bind_conn) else $error("bind not taken");
  property p_nv_fs;
    nv_write |-> nv_failsafe_out == $past(link_values[`RCF_VAL_W-1:0]);
  endproperty
  a_nv_fs: assert property (p_nv_fs) else $error("failsafe not captured");
  property p_no_pulse;
    !connected && !failsafe |-> servo_out == '0;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("pulse before link");
  property p_fs_thr;
    failsafe && $past(failsafe, 4) |-> servo_out[`RCF_CH_COUNT-1:1] == '0;
  endproperty
  a_fs_thr: assert property (p_fs_thr) else $error("pulse in failsafe");
  property p_hold_inc;
    $rose(failsafe) |-> hold_count == $past(hold_count) + 8'h01;
  endproperty
  a_hold_inc: assert property (p_hold_inc) else $error("hold not counted");
  property p_hold_clr;
    $fell(srst) |-> hold_count == '0;
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("hold not cleared");
  property p_loss;
    quiet_cnt > LOSS_CYC |-> !connected;
  endproperty
  a_loss: assert property (p_loss) else $error("link loss missed");
endmodule // rcf_receiver_assertions

bind rcf_receiver rcf_receiver_assertions #(
  .LOSS_CYC(LOSS_CYC),
  .FAST_HALF_CYC(FAST_HALF_CYC)
) rcf_receiver_assertions_inst (
  .clk_sys, .srst, .link_valid, .link_bind, .link_values, .nv_write, .nv_failsafe_out,
  .servo_out, .status_led, .connected, .failsafe, .bind_mode, .hold_count
);

// >>> rcf_receiver_bench.sv
// self-checking bench for the receiver control core
module rcf_receiver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FRAME = 12000;
  localparam int LOSS = 1000;
  // arbitrary transmitter code
  localparam logic [31:0] TX_ID = 32'h5a3c_9e21;
  localparam logic [59:0] VALS = {10'h058, 10'h048, 10'h038, 10'h028, 10'h018, 10'h008};
  logic clk_sys = 1'b0, srst = 1'b1, power_and_pair_port = 1'b0, brownout_pin = 1'b0;
  logic link_valid = 1'b0, link_bind = 1'b0, nv_valid = 1'b0;
  logic [31:0] link_id = '0, nv_id = '0, nv_id_out;
  logic [59:0] link_values = '0;
  logic [9:0] nv_failsafe = '0, nv_failsafe_out;
  logic nv_write, throttle_channel_port, status_led, connected, failsafe, bind_mode, wr_seen;
  logic [5:0] servo_out;
  logic [7:0] hold_count;
  int err_count = 0, total_checks = 0, cyc = 0;
  int snap [6];
  always #50 clk_sys = ~clk_sys;
  rcf_receiver #(.FRAME_CYC(FRAME), .LOSS_CYC(LOSS), .CONNECT_FRAMES(4), .FAST_HALF_CYC(20),
    .SLOW_HALF_CYC(50), .PAUSE_CYC(100)) rcf_receiver_inst (.clk_sys, .srst,
    .power_and_pair_port, .brownout_pin, .link_valid, .link_bind, .link_id, .link_values,
    .nv_valid, .nv_id, .nv_failsafe, .nv_write, .nv_id_out, .nv_failsafe_out, .servo_out,
    .throttle_channel_port, .status_led, .connected, .failsafe, .bind_mode, .hold_count);
  rcf_servo_model rcf_servo_model_inst (.clk_sys, .servo_in(servo_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic jmp, input logic nvv);
    @(negedge clk_sys);
    srst = 1'b1;
    power_and_pair_port = jmp;
    nv_valid = nvv;
    nv_id = TX_ID;
    nv_failsafe = VALS[9:0];
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic send(input logic bnd, input logic [31:0] id);
    @(negedge clk_sys);
    link_valid = 1'b1;
    link_bind = bnd;
    link_id = id;
    link_values = VALS;
    @(negedge clk_sys);
    wr_seen = nv_write;
    link_valid = 1'b0;
  endtask
  // keep-alive frames come well inside the loss timeout
  task automatic idle(input int n, input logic keep);
    for (int i = 0; i < n; i += 400) begin
      if (keep) send(1'b0, TX_ID);
      repeat (keep ? 398 : 400) @(negedge clk_sys);
    end
  endtask
  // any window of whole periods holds a fixed count of rising edges
  task automatic blinks(input int n, input int exp);
    int edges;
    logic last;
    edges = 0;
    last = status_led;
    repeat (n) begin
      @(negedge clk_sys);
      if (status_led && !last) edges++;
      last = status_led;
    end
    check(edges, exp);
  endtask
  task automatic t_bind();
    do_reset(1'b1, 1'b0);
    check(bind_mode, 1'b1);
    check(hold_count, 8'h00);
    // bind only after the loss timeout has long run out
    blinks(1040, 26);
    send(1'b1, TX_ID);
    check(wr_seen, 1'b1);
    check(nv_failsafe_out, VALS[9:0]);
    check(nv_id_out, TX_ID);
    check(connected, 1'b1);
    power_and_pair_port = 1'b0;
    repeat (4) @(negedge clk_sys);
    blinks(60, 0);
    check(status_led, 1'b1);
  endtask
  task automatic t_outputs();
    idle(2 * FRAME + 800, 1'b1);
    for (int i = 0; i < 6; i++) begin
      check(rcf_servo_model_inst.width[i], 10000 + (i * 16 + 8) * 10);
      check(rcf_servo_model_inst.pulses[i] > 0, 1'b1);
    end
  endtask
  task automatic t_failsafe();
    int thr;
    thr = 0;
    idle(LOSS + 400, 1'b0);
    check(failsafe, 1'b1);
    check(hold_count, 8'h01);
    idle(FRAME + 400, 1'b0);
    for (int i = 0; i < 6; i++) snap[i] = rcf_servo_model_inst.pulses[i];
    // one whole frame on the throttle pin holds exactly one failsafe pulse
    repeat (FRAME) begin
      @(negedge clk_sys);
      if (throttle_channel_port === 1'b1) thr++;
    end
    idle(400, 1'b0);
    check(thr, 10000 + 8 * 10);
    check(rcf_servo_model_inst.pulses[0] > snap[0], 1'b1);
    check(rcf_servo_model_inst.width[0], 10000 + 8 * 10);
    for (int i = 1; i < 6; i++) check(rcf_servo_model_inst.pulses[i] - snap[i], 0);
    blinks(420, 3);
  endtask
  task automatic t_restore();
    send(1'b0, ~TX_ID);
    check(failsafe, 1'b1);
    send(1'b0, TX_ID);
    check(connected, 1'b1);
    idle(LOSS + 400, 1'b0);
    check(hold_count, 8'h02);
    repeat (4) @(negedge clk_sys);
    blinks(360, 4);
  endtask
  task automatic t_wait();
    do_reset(1'b0, 1'b1);
    check(hold_count, 8'h00);
    check(bind_mode, 1'b0);
    snap[0] = rcf_servo_model_inst.pulses[0];
    brownout_pin = 1'b1;
    idle(FRAME + 400, 1'b0);
    check(rcf_servo_model_inst.pulses[0] - snap[0], 0);
    blinks(300, 3);
    repeat (4) send(1'b0, ~TX_ID);
    check(connected, 1'b0);
    repeat (4) send(1'b0, TX_ID);
    check(connected, 1'b1);
  endtask
  initial begin
    t_bind();
    t_outputs();
    t_failsafe();
    t_restore();
    t_wait();
    complete_run();
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      complete_run();
    end
  end
endmodule // rcf_receiver_bench
